/* File: bench/pes_regs_sva.sv */
// Checker of the APB side and page field of the event, page and counter bank.
// Assumes it is bound to pes_regs and sees only its ports.
`timescale 1ns/1ps
module pes_regs_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire pes_pkg::pes_word_type pwdata,
	input wire logic pready,
	input wire pes_pkg::pes_word_type prdata,
	input wire logic pslverr,
	// Page
	input wire logic [2:0] page_select
);
	import pes_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_pg;
	assign wr_pg = psel && penable && pready && pwrite && paddr == 32'h4c;
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data outside access");
	chk_bad_addr: assert property (pready && paddr == 32'h7c |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_page_write: assert property (wr_pg |=> page_select == $past(pwdata[2:0]))
		else $error("page write lost");
	chk_page_hold: assert property (!wr_pg |=> $stable(page_select))
		else $error("page changed without write");
	chk_page_read: assert property (pready && !pwrite && paddr == 32'h4c
		|-> prdata == {29'h0, page_select})
		else $error("page read mismatch");
	chk_cnt_upper: assert property (pready && !pwrite && paddr[7:3] == 5'h0a
		|-> prdata[31:8] == 24'h0)
		else $error("counter upper bits set");
	cover property (wr_pg);
	cover property (pready && pslverr);
	cover property (pready && !pwrite && paddr == 32'h54 && prdata == 32'hff);
endmodule : pes_regs_sva
bind pes_regs pes_regs_sva u_pes_regs_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .page_select(page_select));

/* File: bench/tb.sv */
// Testbench of the event, page and counter bank over APB.
// Assumes the design package, header and checker are compiled first.
`timescale 1ns/1ps
module tb;
	import pes_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, carrier_valid, invalid_symbol, collision;
	logic [31:0] paddr;
	pes_word_type pwdata, prdata, rd_data;
	logic pready, pslverr, irq, rd_err;
	logic [2:0] page_select;
	logic [8:0] evt;
	int n_errors, compares;
	int ev[6] = '{8, 7, 6, 5, 4, 2};
	int pb[6] = '{15, 14, 13, 12, 11, 10};
	pes_regs u_pes_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .link_quality_evt(evt[8]), .energy_detect_evt(evt[7]),
		.link_change_evt(evt[6]), .speed_change_evt(evt[5]), .duplex_change_evt(evt[4]),
		.time_sync_evt(evt[3]), .autoneg_done_evt(evt[2]), .ctrl_frame_evt(evt[1]),
		.false_carrier_evt(evt[0]), .carrier_valid(carrier_valid),
		.invalid_symbol(invalid_symbol), .collision(collision), .irq(irq),
		.page_select(page_select));
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task test_done;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task chk(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task apb(logic w, logic [31:0] a, pes_word_type d);
		int i;
		i = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			n_errors++;
			test_done;
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task rd(logic [31:0] a, logic [31:0] exp);
		apb(0, a, 0);
		chk("prdata", rd_data, exp);
	endtask : rd
	task fire(int b, int n);
		evt[b] <= 1;
		repeat (n) @(posedge pclk);
		evt <= 0;
		@(posedge pclk);
	endtask : fire
	task frame(logic inv, logic col);
		carrier_valid <= 1;
		collision <= col;
		@(posedge pclk);
		invalid_symbol <= inv;
		repeat (3) @(posedge pclk);
		invalid_symbol <= 0;
		@(posedge pclk);
		carrier_valid <= 0;
		collision <= 0;
		repeat (2) @(posedge pclk);
	endtask : frame
	task ev_case(logic [31:0] mode, int b, int p, logic [7:0] en);
		apb(1, 32'h80, mode);
		apb(1, 32'h48, {24'h0, en});
		fire(b, 1);
		repeat (2) @(posedge pclk);
		chk("irq", irq, en[p-8]);
		rd(32'h48, (32'h1 << p) | en);
	endtask : ev_case
	initial begin
		{presetn, psel, penable, pwrite, carrier_valid, invalid_symbol, collision} = 0;
		paddr = 0;
		pwdata = 0;
		evt = 0;
		n_errors = 0;
		compares = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int a = 'h48; a <= 'h54; a += 4) rd(a, 0);
		rd(32'h80, 0);
		apb(1, 32'h4c, '1);
		rd(32'h4c, 7);
		chk("page_select", page_select, 7);
		rd(32'h50, 0);
		chk("pslverr", rd_err, 1);
		apb(1, 32'h4c, 0);
		apb(1, 32'h50, '1);
		rd(32'h50, 0);
		rd(32'h7c, 0);
		chk("pslverr", rd_err, 1);
		fire(0, 3);
		rd(32'h50, 3);
		rd(32'h50, 0);
		frame(1, 0);
		rd(32'h54, 1);
		frame(1, 1);
		invalid_symbol <= 1;
		repeat (2) @(posedge pclk);
		invalid_symbol <= 0;
		frame(0, 0);
		rd(32'h54, 0);
		fire(0, 300);
		rd(32'h50, 'hff);
		repeat (260) frame(1, 0);
		rd(32'h54, 'hff);
		rd(32'h48, 32'h300);
		rd(32'h48, 0);
		apb(1, 32'h48, 'hff);
		fire(6, 1);
		repeat (2) @(posedge pclk);
		chk("irq", irq, 0);
		rd(32'h48, 32'h20ff);
		for (int k = 0; k < 6; k++) ev_case(1, ev[k], pb[k], 8'h1 << (pb[k] - 8));
		ev_case(3, 3, 11, 8'h08);
		ev_case(3, 4, 12, 8'h10);
		ev_case(5, 1, 8, 8'h01);
		ev_case(5, 1, 8, 8'h00);
		ev_case(1, 2, 10, 8'h00);
		apb(1, 32'h80, 5);
		apb(1, 32'h48, 32'h02);
		repeat (128) frame(1, 0);
		repeat (3) @(posedge pclk);
		chk("irq", irq, 1);
		rd(32'h48, 32'h202);
		rd(32'h54, 32'h80);
		test_done;
	end
endmodule : tb

/* File: rtl/pes_cfg.svh */
// Register offsets, field positions and reset values of the event, page and counter bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PES_CFG_SVH
`define PES_CFG_SVH
// Register indices; the byte address on APB is four times the index
`define PES_IDX_STATUS_ENABLE 6'h12
`define PES_IDX_PAGE_SELECT 6'h13
`define PES_IDX_FALSE_CARRIER 6'h14
`define PES_IDX_RX_ERROR 6'h15
`define PES_IDX_MODE_CONTROL 6'h20
`define PES_ADDR_LSB 2
`define PES_ADDR_MSB 7
// Status and enable field layout
`define PES_PEND_MSB 15
`define PES_PEND_LSB 8
`define PES_EN_MSB 7
`define PES_EN_LSB 0
// Page select field
`define PES_PAGE_MSB 2
`define PES_PAGE_LSB 0
`define PES_PAGE_EXTENDED 3'h0
// Mode control fields
`define PES_MODE_GLOBAL_EN 0
`define PES_MODE_TS_SEL 1
`define PES_MODE_ALT_LSB 2
`define PES_MODE_ALT_MSB 3
// Counter field and reset values
`define PES_CNT_MSB 7
`define PES_CNT_LSB 0
`define PES_CNT_WIDTH 8
`define PES_RESET_BYTE 8'h00
`define PES_RESET_PAGE 3'h0
`define PES_RESET_WORD 32'h0000_0000
`endif

/* File: rtl/pes_cnt_if.sv */
// Link between the register bank and one saturating event counter.
// Assumes both ends run on the bank clock.
`timescale 1ns/1ps
interface pes_cnt_if #(parameter int WIDTH = 8);
	logic inc;
	logic clr;
	logic [WIDTH-1:0] clr_val;
	logic [WIDTH-1:0] count;
	logic half;
	modport bank (output inc, output clr, output clr_val, input count, input half);
	modport counter (input inc, input clr, input clr_val, output count, output half);
endinterface : pes_cnt_if

/* File: rtl/pes_pkg.sv */
// Types shared by the event, page and counter bank.
// Assumes the constants header sits in the include path.
`include "pes_cfg.svh"
package pes_pkg;
	typedef logic [31:0] pes_word_type;
	typedef struct packed {
		logic [7:0] pend;
		logic [7:0] en;
		logic [2:0] page;
		logic glob_en;
		logic ts_sel;
		logic [1:0] alt_sel;
		logic carrier_d;
		logic seen_bad;
		logic seen_coll;
		logic ready;
		pes_word_type rdata;
		logic slverr;
		logic irq;
	} pes_state_type;
endpackage : pes_pkg

/* File: rtl/pes_regs.sv */
// Event status and enable, page select and the two error counters behind an APB slave.
// Assumes event inputs are one-cycle pulses and carrier and collision are levels, all on pclk.
//
// How it works
// R1: With alternate selection off, status bit 8 flags receive error half-full; read clears.
// R2: With alternate selection on, status bit 8 flags a control frame; read clears.
// R3: Enable bits 7..4 gate link quality, energy detect, link and speed interrupts.
// R4: Enable bit 3 gates duplex change, or time sync when that mode is chosen.
// R5: Enable bit 2 gates the auto-negotiation complete interrupt.
// R6: Enable bit 1 gates false carrier half-full, or either counter half-full.
// R7: Enable bit 0 gates receive error half-full, or the control frame event.
// R8: Three-bit page field, reset zero, picks the page answering at 14h and 15h.
// R9: Reserved upper bits of page and counter registers ignore writes, read zero.
// R10: False carrier counter counts each event, sticks at FFh, clears on read.
// R11: Receive error counts only under valid carrier with an invalid symbol seen.
// R12: Receive error counter advances at most once per carrier event.
// R13: A carrier event with collision never advances the receive error counter.
// R14: Receive error counter saturates at maximum and clears on read.
// R15: Pending bits set regardless of enables; interrupt needs event and global enable.
// R16: Global interrupt enable, reset zero, permits the per-event interrupts.
// R17: Half-full means the counter top bit rises at 80h; one event then.
// R18: One alternate-function selection field serves every alternate choice; the time sync choice uses its own ts_sel bit instead.
`timescale 1ns/1ps
`include "pes_cfg.svh"
module pes_regs (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire pes_pkg::pes_word_type pwdata,
	output logic pready,
	output pes_pkg::pes_word_type prdata,
	output logic pslverr,
	// Event pulses
	input wire logic link_quality_evt,
	input wire logic energy_detect_evt,
	input wire logic link_change_evt,
	input wire logic speed_change_evt,
	input wire logic duplex_change_evt,
	input wire logic time_sync_evt,
	input wire logic autoneg_done_evt,
	input wire logic ctrl_frame_evt,
	input wire logic false_carrier_evt,
	// Receive path levels and pulses
	input wire logic carrier_valid,
	input wire logic invalid_symbol,
	input wire logic collision,
	// Results
	output logic irq,
	output logic [2:0] page_select
);
	import pes_pkg::*;
	pes_state_type state_reg;
	pes_state_type state_next;
	pes_cnt_if #(.WIDTH(`PES_CNT_WIDTH)) fc_if ();
	pes_cnt_if #(.WIDTH(`PES_CNT_WIDTH)) re_if ();
	logic [5:0] idx;
	logic setup;
	logic access;
	logic rd_done;
	logic wr_done;
	logic alt_on;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic re_inc;
	logic paged_ok;
	pes_word_type rd_word;
	logic rd_err;

	pes_sat_counter #(.WIDTH(`PES_CNT_WIDTH)) u_false_carrier (
		.pclk(pclk),
		.presetn(presetn),
		.cnt(fc_if)
	);
	pes_sat_counter #(.WIDTH(`PES_CNT_WIDTH)) u_rx_error (
		.pclk(pclk),
		.presetn(presetn),
		.cnt(re_if)
	);

	assign idx = paddr[`PES_ADDR_MSB:`PES_ADDR_LSB];
	assign setup = psel && !penable;
	assign access = psel && penable && state_reg.ready;
	assign rd_done = access && !pwrite && !state_reg.slverr;
	assign wr_done = access && pwrite && !state_reg.slverr;
	assign alt_on = |state_reg.alt_sel; // see R18
	assign paged_ok = (state_reg.page == `PES_PAGE_EXTENDED); // see R8

	// Read data and address decode, taken in the setup cycle
	always_comb begin
		rd_word = `PES_RESET_WORD;
		rd_err = 1'b0;
		if (paddr[1:0] != 2'h0 || paddr[31:`PES_ADDR_MSB+1] != '0) begin
			rd_err = 1'b1;
		end else begin
			case (idx)
				`PES_IDX_STATUS_ENABLE: begin
					rd_word[`PES_PEND_MSB:`PES_PEND_LSB] = state_reg.pend;
					rd_word[`PES_EN_MSB:`PES_EN_LSB] = state_reg.en;
				end
				`PES_IDX_PAGE_SELECT: begin
					rd_word[`PES_PAGE_MSB:`PES_PAGE_LSB] = state_reg.page; // see R9
				end
				`PES_IDX_FALSE_CARRIER: begin
					rd_err = !paged_ok;
					rd_word[`PES_CNT_MSB:`PES_CNT_LSB] = fc_if.count; // see R9
				end
				`PES_IDX_RX_ERROR: begin
					rd_err = !paged_ok;
					rd_word[`PES_CNT_MSB:`PES_CNT_LSB] = re_if.count; // see R9
				end
				`PES_IDX_MODE_CONTROL: begin
					rd_word[`PES_MODE_GLOBAL_EN] = state_reg.glob_en;
					rd_word[`PES_MODE_TS_SEL] = state_reg.ts_sel;
					rd_word[`PES_MODE_ALT_MSB:`PES_MODE_ALT_LSB] = state_reg.alt_sel;
				end
				default: begin
					rd_err = 1'b1;
				end
			endcase
		end
		if (rd_err) begin
			rd_word = `PES_RESET_WORD;
		end
	end

	// Event sources onto the pending bits, which set whatever the enables say
	always_comb begin
		set_bits = `PES_RESET_BYTE;
		set_bits[7] = link_quality_evt; // see R15
		set_bits[6] = energy_detect_evt;
		set_bits[5] = link_change_evt;
		set_bits[4] = state_reg.ts_sel ? (speed_change_evt || duplex_change_evt)
			: speed_change_evt;
		set_bits[3] = state_reg.ts_sel ? time_sync_evt : duplex_change_evt; // see R4
		set_bits[2] = autoneg_done_evt; // see R5
		set_bits[1] = alt_on ? (fc_if.half || re_if.half) : fc_if.half; // see R6, R17
		set_bits[0] = alt_on ? ctrl_frame_evt : re_if.half; // see R1, R2, R7, R17
	end

	// Receive error qualification across one carrier event
	assign re_inc = state_reg.carrier_d && !carrier_valid && state_reg.seen_bad
		&& !state_reg.seen_coll; // see R11, R12, R13

	assign fc_if.inc = false_carrier_evt; // see R10
	assign re_if.inc = re_inc; // see R11
	assign fc_if.clr = rd_done && (idx == `PES_IDX_FALSE_CARRIER); // see R10
	assign re_if.clr = rd_done && (idx == `PES_IDX_RX_ERROR); // see R14
	assign fc_if.clr_val = state_reg.rdata[`PES_CNT_MSB:`PES_CNT_LSB];
	assign re_if.clr_val = state_reg.rdata[`PES_CNT_MSB:`PES_CNT_LSB];

	// Only the pending bits that the read returned are cleared
	always_comb begin
		clr_bits = `PES_RESET_BYTE;
		if (rd_done && (idx == `PES_IDX_STATUS_ENABLE)) begin
			clr_bits = state_reg.rdata[`PES_PEND_MSB:`PES_PEND_LSB]; // see R1, R2
		end
	end

	always_comb begin
		state_next = state_reg;
		// Pending bits: set wins over clear
		state_next.pend = (state_reg.pend & ~clr_bits) | set_bits; // see R15
		// Carrier tracking
		state_next.carrier_d = carrier_valid;
		if (carrier_valid) begin
			state_next.seen_bad = state_reg.seen_bad || invalid_symbol; // see R11
			state_next.seen_coll = state_reg.seen_coll || collision; // see R13
		end else begin
			state_next.seen_bad = 1'b0; // see R12
			state_next.seen_coll = 1'b0;
		end
		// Register writes at the completing edge
		if (wr_done) begin
			case (idx)
				`PES_IDX_STATUS_ENABLE: begin
					state_next.en = pwdata[`PES_EN_MSB:`PES_EN_LSB]; // see R3
				end
				`PES_IDX_PAGE_SELECT: begin
					state_next.page = pwdata[`PES_PAGE_MSB:`PES_PAGE_LSB]; // see R8, R9
				end
				`PES_IDX_MODE_CONTROL: begin
					state_next.glob_en = pwdata[`PES_MODE_GLOBAL_EN]; // see R16
					state_next.ts_sel = pwdata[`PES_MODE_TS_SEL];
					state_next.alt_sel = pwdata[`PES_MODE_ALT_MSB:`PES_MODE_ALT_LSB];
				end
				default: begin
				end
			endcase
		end
		// APB answer: no wait state, data and error fixed in the setup cycle
		if (setup) begin
			state_next.ready = 1'b1;
			state_next.rdata = pwrite ? `PES_RESET_WORD : rd_word;
			state_next.slverr = rd_err;
		end else if (access) begin
			state_next.ready = 1'b0;
			state_next.rdata = `PES_RESET_WORD;
			state_next.slverr = 1'b0;
		end
		// Interrupt needs a pending bit, its enable and the global enable
		state_next.irq = state_reg.glob_en && |(state_reg.pend & state_reg.en); // see R15, R16
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pready = state_reg.ready;
	assign prdata = state_reg.rdata;
	assign pslverr = state_reg.slverr;
	assign irq = state_reg.irq;
	assign page_select = state_reg.page;
endmodule : pes_regs

/* File: rtl/pes_sat_counter.sv */
// Saturating clear-on-read event counter with a half-full pulse.
// Assumes increments and clears come synchronous to pclk.
`timescale 1ns/1ps
`include "pes_cfg.svh"
module pes_sat_counter #(
	parameter int WIDTH = `PES_CNT_WIDTH
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bank side
	pes_cnt_if.counter cnt
);
	import pes_pkg::*;
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic half;
	} pes_cnt_state_type;
	localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
	pes_cnt_state_type state_reg;
	pes_cnt_state_type state_next;
	logic [WIDTH-1:0] base;
	always_comb begin
		state_next = state_reg;
		base = state_reg.count;
		// Remove only what the read showed, so a late event survives the clear
		if (cnt.clr) begin
			base = state_reg.count - cnt.clr_val; // see R10, R14
		end
		state_next.count = base;
		if (cnt.inc && (base != MAX_COUNT)) begin
			state_next.count = base + ONE; // see R10, R14
		end
		state_next.half = state_next.count[WIDTH-1] && !state_reg.count[WIDTH-1]; // see R17
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign cnt.count = state_reg.count;
	assign cnt.half = state_reg.half;
endmodule : pes_sat_counter
